// ===== alias_priority_pick.sv
// Lowest numbered hitting slot wins when aliases overlap
`timescale 1ns/1ns

module alias_priority_pick
(
  input  wire logic [4:0]  hits,
  input  wire logic [34:0] phys_flat,
  input  wire logic [4:0]  acks,
  output logic             any_hit,
  output logic [6:0]       phys_sel,
  output logic             ack_sel,
  output logic [2:0]       slot_sel
);

  always_comb
  begin
    any_hit  = 1'b0;
    phys_sel = 7'h00;
    ack_sel  = 1'b0;
    slot_sel = 3'h0;
    for (int i = 4; i >= 0; i--)
    begin
      if (hits[i])
      begin
        any_hit  = 1'b1;
        phys_sel = phys_flat[i*7 +: 7];
        ack_sel  = acks[i];
        slot_sel = 3'(i + 1);
      end
    end
  end

endmodule : alias_priority_pick

// ===== alias_slot_match.sv
// One alias slot: compares an address against the programmed alias
`timescale 1ns/1ns
`include "alias_slots_defines.svh"

module alias_slot_match
(
  input  wire logic [7:0] slot_reg,
  input  wire logic [7:0] target_reg,
  input  wire logic [6:0] addr_in,
  output logic            hit,
  output logic [6:0]      phys_addr,
  output logic            auto_ack
);

  logic [6:0] alias_addr;

  assign alias_addr = slot_reg[`ALIAS_FIELD_MSB:`ALIAS_FIELD_LSB];
  // Zero alias means the slot is off
  assign hit        = (alias_addr != 7'h00) && (alias_addr == addr_in); // [R01] [R03]
  assign phys_addr  = target_reg[`ALIAS_FIELD_MSB:`ALIAS_FIELD_LSB]; // [R07]
  assign auto_ack   = slot_reg[`AUTO_ACK_BIT];

endmodule : alias_slot_match

// ===== alias_slots_defines.svh
// Register offsets, field positions and reset values of the alias slot bank
`ifndef ALIAS_SLOTS_DEFINES_SVH
`define ALIAS_SLOTS_DEFINES_SVH

`define SLOT_COUNT          5
`define ADDR_WIDTH          8
`define DATA_WIDTH          32
`define REMOTE_ALIAS_SLOT_1 8'h42
`define REMOTE_ALIAS_SLOT_2 8'h43
`define REMOTE_ALIAS_SLOT_3 8'h44
`define REMOTE_ALIAS_SLOT_4 8'h45
`define REMOTE_ALIAS_SLOT_5 8'h46
`define REMOTE_TARGET_ID_1  8'h50
`define REMOTE_TARGET_ID_5  8'h54
`define ALIAS_STATUS        8'h58
`define ALIAS_FIELD_MSB     7
`define ALIAS_FIELD_LSB     1
`define AUTO_ACK_BIT        0
`define SLOT_RESET          8'h00
`define READ_LATENCY        2'h1

`endif

// ===== alias_slots_monitor.sv
// Concurrent checks on the alias slot bank ports
`timescale 1ns/1ns

module alias_slots_monitor
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic       avs_waitrequest,
  input  wire logic       req_valid,
  input  wire logic [6:0] req_addr,
  input  wire logic       req_write,
  input  wire logic       fwd_valid,
  input  wire logic       fwd_write,
  input  wire logic [2:0] fwd_slot,
  input  wire logic       auto_ack,
  input  wire logic       req_reject
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_ZERO_OFF: assert property (req_valid && req_addr == 7'h00 |=> req_reject)
    else $error("zero address was decoded");
  AST_ONE_OUTCOME: assert property (req_valid |=> fwd_valid ^ req_reject)
    else $error("request not forwarded or rejected exactly once");
  AST_NO_REQ: assert property (!req_valid |=> !fwd_valid && !req_reject && !auto_ack)
    else $error("output without a request");
  AST_ACK_READ: assert property (req_valid && !req_write |=> !auto_ack)
    else $error("auto acknowledge on a read");
  AST_ACK_FWD: assert property (auto_ack |-> fwd_valid && fwd_write)
    else $error("auto acknowledge without forwarded write");
  AST_SLOT_RANGE: assert property (fwd_valid |-> fwd_slot inside {[3'h1:3'h5]})
    else $error("forwarded slot out of range");
  AST_REJ_CLEAN: assert property (req_reject |-> fwd_slot == 3'h0 && !auto_ack)
    else $error("rejected request carries slot or ack");
  AST_WR_PASS: assert property (req_valid |=> !fwd_valid || fwd_write == $past(req_write))
    else $error("direction changed when forwarded");
  AST_BUS_ANSWER: assert property ($rose(avs_read || avs_write) |-> ##[1:2] !avs_waitrequest)
    else $error("register access not answered");

  cover property (auto_ack);
  cover property (req_reject);
  cover property (fwd_valid && fwd_slot == 3'h5);
endmodule : alias_slots_monitor

bind i2c_remote_alias_slots alias_slots_monitor alias_slots_monitor_inst (.clk_sys, .rst_b,
  .avs_read, .avs_write, .avs_waitrequest, .req_valid, .req_addr, .req_write, .fwd_valid,
  .fwd_write, .fwd_slot, .auto_ack, .req_reject);

// ===== alias_slots_pkg.sv
// Types shared by the alias slot bank
package alias_slots_pkg;

  typedef logic [6:0] i2c_addr_t;
  typedef logic [7:0] slot_reg_t;

  typedef enum logic [1:0]
  {
    BUS_IDLE,
    BUS_WAIT,
    BUS_DONE
  } bus_state_t;

endpackage : alias_slots_pkg

// ===== i2c_ctl_model.sv
// Local I2C controller model issuing one address request per call
`timescale 1ns/1ns

module i2c_ctl_model
(
  input  wire logic       clk_sys,
  output logic            req_valid,
  output logic [6:0]      req_addr,
  output logic            req_write
);
  initial
  begin
    req_valid = 1'b0;
    req_addr  = 7'h55;
    req_write = 1'b0;
  end

  // Idle lines show inverted values so a stale address can never pass
  task automatic issue(input logic [6:0] a, input logic wr);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_addr  <= a;
    req_write <= wr;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    req_addr  <= ~a;
    req_write <= ~wr;
  endtask : issue
endmodule : i2c_ctl_model

// ===== i2c_remote_alias_slots.sv
// Alias decoder slots 1..5 with remote target remap and Avalon-MM registers
//
// Functional notes
// R01 - Each slot holds a 7-bit alias in bits 7:1, reset zero, compared to addresses.
// R02 - A matching address is replaced by the slot's remote target address.
// R03 - Alias value zero disables the slot entirely.
// R04 - Bit 0 set: acknowledge every write to that target regardless of link.
// R05 - Software should keep auto-acknowledge clear except when debugging.
// R06 - Slots 1 to 5 sit at offsets 0x42 to 0x46, paired by index.
// R07 - Remote target registers hold the physical address in bits 7:1.
// R08 - The remapped transaction is passed on toward the control channel.
// R09 - Unmatched addresses are not forwarded, remapped or auto-acknowledged.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "alias_slots_defines.svh"

module i2c_remote_alias_slots
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  input  wire logic        req_valid,
  input  wire logic [6:0]  req_addr,
  input  wire logic        req_write,
  output logic             fwd_valid,
  output logic [6:0]       fwd_addr,
  output logic             fwd_write,
  output logic [2:0]       fwd_slot,
  output logic             auto_ack,
  output logic             req_reject
);

  //////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] alias_q  [`SLOT_COUNT];
  logic [7:0] target_q [`SLOT_COUNT];
  logic [7:0] hit_count_q;
  logic [2:0] last_slot_q;

  alias_slots_pkg::bus_state_t bus_state_q;
  alias_slots_pkg::bus_state_t bus_state_d;

  logic       bus_req;
  logic       bus_idle;
  logic       wr_take;
  logic [4:0] alias_wr;
  logic [4:0] target_wr;
  logic       alias_sel;
  logic       target_sel;
  logic [2:0] alias_idx;
  logic [2:0] target_idx;
  logic       mapped;

  // Requests are taken at the edge where waitrequest is low
  assign bus_req    = avs_read || avs_write;
  assign bus_idle   = (bus_state_q == alias_slots_pkg::BUS_IDLE);
  assign wr_take    = avs_write && !avs_waitrequest;
  assign alias_sel  = (avs_address >= `REMOTE_ALIAS_SLOT_1) &&
                      (avs_address <= `REMOTE_ALIAS_SLOT_5); // [R06]
  assign target_sel = (avs_address >= `REMOTE_TARGET_ID_1) &&
                      (avs_address <= `REMOTE_TARGET_ID_5);
  assign alias_idx  = 3'(avs_address - `REMOTE_ALIAS_SLOT_1);
  assign target_idx = 3'(avs_address - `REMOTE_TARGET_ID_1);
  // Anything outside these ranges and the status address answers DECODEERROR
  assign mapped     = alias_sel || target_sel || (avs_address == `ALIAS_STATUS);

  // Per-slot write strobes; a write with byte lane 0 off changes nothing
  genvar g;
  generate
    for (g = 0; g < `SLOT_COUNT; g++)
    begin : g_wr
      assign alias_wr[g]  = wr_take && avs_byteenable[0] && alias_sel &&
                            (alias_idx == 3'(g)); // [R06]
      assign target_wr[g] = wr_take && avs_byteenable[0] && target_sel &&
                            (target_idx == 3'(g)); // [R06]
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle per access, then accept

  always_comb
  begin
    bus_state_d = bus_state_q;
    case (bus_state_q)
      alias_slots_pkg::BUS_IDLE:
      begin
        if (bus_req)
          bus_state_d = alias_slots_pkg::BUS_WAIT;
      end
      alias_slots_pkg::BUS_WAIT:
        bus_state_d = alias_slots_pkg::BUS_DONE;
      alias_slots_pkg::BUS_DONE:
        bus_state_d = alias_slots_pkg::BUS_IDLE;
      default:
        bus_state_d = alias_slots_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      bus_state_q <= alias_slots_pkg::BUS_IDLE;
    else
      bus_state_q <= bus_state_d;
  end

  // Held high while idle; drops for exactly one cycle per access
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !(bus_idle && bus_req);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Slot and target registers, byte lane 0 only

  generate
    for (g = 0; g < `SLOT_COUNT; g++)
    begin : g_slot
      // Bit 0 is kept even while the alias is zero; it acts only once enabled
      always_ff @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
          alias_q[g] <= `SLOT_RESET; // [R01]
        else if (alias_wr[g])
          alias_q[g] <= avs_writedata[7:0]; // [R01] [R04] [R06]
      end

      // Bit 0 of a target byte is reserved and always reads zero
      always_ff @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
          target_q[g] <= `SLOT_RESET;
        else if (target_wr[g])
          target_q[g] <= {avs_writedata[7:1], 1'b0}; // [R07]
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read data, valid at the accepting edge

  logic [31:0] rd_d;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (alias_sel)
      rd_d = {24'h00_0000, alias_q[alias_idx]};
    else if (target_sel)
      rd_d = {24'h00_0000, target_q[target_idx]};
    else if (avs_address == `ALIAS_STATUS)
      rd_d = {16'h0000, hit_count_q, 5'h00, last_slot_q};
  end

  // Captured at the edge that drops waitrequest, so it stands while waitrequest is low
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      avs_readdata <= 32'h0000_0000;
    else if (bus_idle && avs_read)
      avs_readdata <= rd_d;
  end

  // Unmapped addresses answer DECODEERROR with zero data
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      avs_response <= 2'h0;
    else if (bus_idle && bus_req)
      avs_response <= mapped ? 2'h0 : 2'h3;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address decode across all slots

  logic [4:0]  hits;
  logic [4:0]  acks;
  logic [34:0] phys_flat;
  logic        any_hit;
  logic [6:0]  phys_sel;
  logic        ack_sel;
  logic [2:0]  slot_sel;

  // One comparator per slot; decode is combinational, outputs are registered
  generate
    for (g = 0; g < `SLOT_COUNT; g++)
    begin : g_match
      alias_slot_match u_match
      (
        .slot_reg   (alias_q[g]),
        .target_reg (target_q[g]),
        .addr_in    (req_addr),
        .hit        (hits[g]),
        .phys_addr  (phys_flat[g*7 +: 7]),
        .auto_ack   (acks[g])
      );
    end
  endgenerate

  // Overlapping aliases resolve to the lowest slot number
  alias_priority_pick u_pick
  (
    .hits      (hits),
    .phys_flat (phys_flat),
    .acks      (acks),
    .any_hit   (any_hit),
    .phys_sel  (phys_sel),
    .ack_sel   (ack_sel),
    .slot_sel  (slot_sel)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Forwarding toward the control channel, one cycle after the request
  // One flop per output, so the far side sees no decode path

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      fwd_valid <= 1'b0;
    else
      fwd_valid <= req_valid && any_hit; // [R08] [R09]
  end

  // A miss shows address zero, so no stale target leaks out
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      fwd_addr <= 7'h00;
    else
      fwd_addr <= any_hit ? phys_sel : 7'h00; // [R02]
  end

  // Direction passes through unchanged
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      fwd_write <= 1'b0;
    else
      fwd_write <= req_valid && any_hit && req_write; // [R08]
  end

  // Slot numbers are one-based; zero means no slot took the request
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      fwd_slot <= 3'h0;
    else
      fwd_slot <= any_hit ? slot_sel : 3'h0; // [R06]
  end

  // Debug ack ignores link lock and the remote answer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      auto_ack <= 1'b0;
    else
      auto_ack <= req_valid && any_hit && req_write && ack_sel; // [R04] [R09]
  end

  // A miss is flagged so the local controller can refuse the transfer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      req_reject <= 1'b0;
    else
      req_reject <= req_valid && !any_hit; // [R09]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status: count of forwarded requests and the last slot used

  // Count wraps at 255; software works on differences
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      hit_count_q <= 8'h00;
    else if (req_valid && any_hit)
      hit_count_q <= hit_count_q + 8'h01;
  end

  // Holds until another request is forwarded
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      last_slot_q <= 3'h0;
    else if (req_valid && any_hit)
      last_slot_q <= slot_sel;
  end

endmodule : i2c_remote_alias_slots

// ===== tb_top.sv
// Self-checking bench for the alias slot bank
`timescale 1ns/1ns

module tb_top;
  logic        clk_sys;
  logic        rst_b;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic        req_valid;
  logic [6:0]  req_addr;
  logic        req_write;
  logic        fwd_valid;
  logic [6:0]  fwd_addr;
  logic        fwd_write;
  logic [2:0]  fwd_slot;
  logic        auto_ack;
  logic        req_reject;
  logic [31:0] rd_q;
  logic [1:0]  rsp_q;
  int          err_total;
  int          n_compared;
  int          cyc;

  i2c_remote_alias_slots i2c_remote_alias_slots_inst (.clk_sys, .rst_b, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .avs_response, .req_valid, .req_addr, .req_write, .fwd_valid,
    .fwd_addr, .fwd_write, .fwd_slot, .auto_ack, .req_reject);
  i2c_ctl_model i2c_ctl_model_inst (.clk_sys, .req_valid, .req_addr, .req_write);

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits on waitrequest; a hang is caught by the cycle ceiling
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] wd);
    @(posedge clk_sys);
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_address   <= a;
    avs_writedata <= {24'h000000, wd};
    do @(posedge clk_sys); while (avs_waitrequest);
    rd_q  = avs_readdata;
    rsp_q = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic send(input logic [6:0] a, input logic wr);
    i2c_ctl_model_inst.issue(a, wr);
    #1;
  endtask : send

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b1, 8'h42 + 8'(i), 8'h00);
      chk("slot reset", 32'h0, rd_q);
      chk("slot response", 32'h0, rsp_q);
    end
    bus(1'b1, 8'h60, 8'h00);
    chk("unmapped response", 32'h3, rsp_q);
  endtask : t_reset

  task automatic t_remap;
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, 8'h42 + 8'(i), {7'h11 + 7'(i), 1'b0});
      bus(1'b0, 8'h50 + 8'(i), {7'h31 + 7'(i), 1'b0});
      bus(1'b1, 8'h42 + 8'(i), 8'h00);
      chk("alias readback", {24'h0, 7'h11 + 7'(i), 1'b0}, rd_q);
      bus(1'b1, 8'h50 + 8'(i), 8'h00);
      chk("target readback", {24'h0, 7'h31 + 7'(i), 1'b0}, rd_q);
    end
    for (int i = 0; i < 5; i++)
    begin
      send(7'h11 + 7'(i), 1'b0);
      chk("fwd_valid", 32'h1, fwd_valid);
      chk("fwd_addr", 7'h31 + 7'(i), fwd_addr);
      chk("fwd_slot", i + 1, fwd_slot);
    end
  endtask : t_remap

  task automatic t_auto_ack;
    bus(1'b0, 8'h44, {7'h13, 1'b1});
    send(7'h13, 1'b1);
    chk("auto_ack write", 32'h1, auto_ack);
    chk("fwd_write", 32'h1, fwd_write);
    send(7'h13, 1'b0);
    chk("auto_ack read", 32'h0, auto_ack);
    send(7'h11, 1'b1);
    chk("auto_ack clear", 32'h0, auto_ack);
    bus(1'b0, 8'h44, {7'h13, 1'b0});
  endtask : t_auto_ack

  task automatic t_disable;
    bus(1'b0, 8'h43, 8'h01);
    send(7'h12, 1'b1);
    chk("disabled reject", 32'h1, req_reject);
    chk("disabled ack", 32'h0, auto_ack);
    send(7'h00, 1'b0);
    chk("zero reject", 32'h1, req_reject);
    send(7'h7F, 1'b1);
    chk("miss reject", 32'h1, req_reject);
    chk("miss fwd", 32'h0, fwd_valid);
  endtask : t_disable

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      print_verdict();
    end
  end

  initial
  begin
    rst_b         = 1'b0;
    avs_address   = 8'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_remap();
    t_auto_ack();
    t_disable();
    print_verdict();
  end
endmodule : tb_top
